// ### design/jfp_port.sv
// flash programming data registers behind the test access port
//
// Behaviour
// (RL1) page-load update copies byte to holding register, lands within 11 test clocks
// (RL2) page-load alternates low then high byte per update, low first
// (RL3) page-load pre-increments word address before low bytes except the first
// (RL4) code 0x7 selects page read through the low 8 command bits
// (RL5) page-read capture loads addressed byte, low first, alternating
// (RL6) page-read post-increments address after every high byte
// (RL7) page-read shift moves one bit per test clock
// (RL8) reset register bit holds part in reset immediately, unlatched
// (RL9) after reset bit clears, reset stays for the time-out period
// (RL10) programmer resets the part before entering programming mode
// (RL11) programming enabled only when key equals 1010_0011_0111_0000
// (RL12) key register clears at power-on; programmer clears on leaving
// (RL13) command register shifts new command in while old result shifts out
// (RL14) chip erase sequence, then poll erase-complete flag in output
// (RL15) flash write entry then extended, high and low address bytes
// (RL16) data low and high loaded, latched by three-step sequence
// (RL17) page write sequence then poll until write complete
// (RL18) flash read returns low byte then high byte in output
// (RL19) eeprom write entry, address, data byte, then latch sequence
// (RL20) eeprom page write four-step sequence
// (RL21) code 0x6 selects page load through the low 8 command bits
// (RL22) command capture loads result, update applies, idle runs one step
// (RL23) key update compares key and enters programming mode when valid
// (RL24) without programming mode, commands, loads and reads are ignored
`include "jfp_map.svh"
module jfp_port #(
  parameter int        MEM_DEPTH    = 1024,
  parameter logic [15:0] BUSY_CYCLES  = `JFP_BUSY_CYCLES,
  parameter logic [15:0] TIMEOUT_CYCLES = `JFP_TIMEOUT_CYCLES
) (
  input  wire logic                      mclk,
  input  wire logic                      reset,
  input  wire logic                      tck,
  input  wire logic                      tdi,
  input  wire jfp_pkg::jfp_tap_type      tap_state,
  input  wire logic [`JFP_INSTR_W-1:0]   instr,
  input  wire logic                      reset_reg_sel,
  output logic                           tdo,
  output logic                           part_reset,
  output logic                           prog_enabled
);
  import jfp_pkg::*;

  initial begin
    if (BUSY_CYCLES == 16'h0000 || TIMEOUT_CYCLES == 16'h0000) $error("jfp_port: zero count");
  end

  // ****************************************************************
  // synchronisers and test clock edge detection
  // ****************************************************************
  logic [1:0] tck_sync;
  logic       tck_last;
  logic [1:0] tdi_sync;
  logic       tck_rise;
  // two stages for the pin, edge taken only from the second
  always_ff @(posedge mclk) begin
    tck_sync <= {tck_sync[0], tck};
    tdi_sync <= {tdi_sync[0], tdi};
    tck_last <= reset ? 1'b0 : tck_sync[1];
  end
  assign tck_rise = tck_sync[1] & ~tck_last;

  // state and instruction are sampled with the test clock, so they are stable here
  function automatic logic in_state(input jfp_tap_type s, input jfp_tap_type want);
    return s == want;
  endfunction

  logic         on_capture;
  logic         on_shift;
  logic         on_update;
  logic         on_idle;
  logic         entered_instr;
  logic         fresh_instr;
  logic [`JFP_INSTR_W-1:0] last_instr;
  assign on_capture = tck_rise & in_state(tap_state, JFP_ST_CAPTURE);
  assign on_shift   = tck_rise & in_state(tap_state, JFP_ST_SHIFT);
  assign on_update  = tck_rise & in_state(tap_state, JFP_ST_UPDATE);
  assign on_idle    = tck_rise & in_state(tap_state, JFP_ST_IDLE);
  // instruction differs from the one seen at the last test clock rise
  assign fresh_instr   = instr != last_instr;
  assign entered_instr = tck_rise & fresh_instr;

  // instruction tracker for the low-byte-first restart
  always_ff @(posedge mclk) begin
    if (reset) begin
      last_instr <= '0;
    end else if (tck_rise) begin
      last_instr <= instr;
    end
  end

  // ****************************************************************
  // reset register and time-out
  // ****************************************************************
  logic        reset_bit;
  logic [15:0] timeout_count;
  always_ff @(posedge mclk) begin
    if (reset) begin
      reset_bit <= 1'b0;
    end else if (on_shift && reset_reg_sel) begin
      reset_bit <= tdi_sync[1];
    end
  end
  // (RL9) time-out after release
  always_ff @(posedge mclk) begin
    if (reset || reset_bit) begin
      timeout_count <= TIMEOUT_CYCLES;
    end else if (timeout_count != 16'h0000) begin
      timeout_count <= timeout_count - 16'h0001;
    end
  end
  // (RL8) unlatched reset output
  assign part_reset = reset_bit | (timeout_count != 16'h0000);

  // ****************************************************************
  // programming key register
  // ****************************************************************
  logic [`JFP_KEY_W-1:0] key_reg;
  logic                  key_sel;
  assign key_sel = (instr == `JFP_INSTR_KEY) && !reset_reg_sel;
  // (RL12) cleared at power-on
  always_ff @(posedge mclk) begin
    if (reset) begin
      key_reg <= '0;
    end else if (on_shift && key_sel) begin
      key_reg <= {tdi_sync[1], key_reg[`JFP_KEY_W-1:1]};
    end
  end
  // (RL23) key compare at update
  always_ff @(posedge mclk) begin
    if (reset) begin
      prog_enabled <= 1'b0;
    end else if (on_update && key_sel) begin
      // (RL11) fixed key compare
      prog_enabled <= (key_reg == `JFP_KEY_VALUE);
    end
  end

  // ****************************************************************
  // command register, page byte register and execution
  // ****************************************************************
  logic [`JFP_CMD_W-1:0]  cmd_reg;
  logic [`JFP_CMD_W-1:0]  applied_cmd;
  logic [`JFP_CMD_W-1:0]  result;
  logic [7:0]             mode;
  logic [`JFP_ADDR_W-1:0] word_addr;
  logic [15:0]            data_word;
  logic [7:0]             ee_byte;
  logic                   busy;
  logic [15:0]            busy_count;
  logic                   cmd_sel;
  logic                   load_sel;
  logic                   read_sel;
  logic                   high_next;
  logic                   first_load;
  logic                   eff_high;
  logic                   eff_first;
  logic                   latch_armed;
  logic [7:0]             hold_byte;
  logic [3:0]             load_count;
  logic                   mem_wr;
  logic [15:0]            mem_wdata;
  logic [15:0]            mem_rdata;
  logic [6:0]             op;
  // (RL24) selections only while programming is enabled
  assign cmd_sel  = prog_enabled && !reset_reg_sel && instr == `JFP_INSTR_CMD;
  assign load_sel = prog_enabled && !reset_reg_sel && instr == `JFP_INSTR_LOAD;
  assign read_sel = prog_enabled && !reset_reg_sel && instr == `JFP_INSTR_READ;
  assign op       = applied_cmd[14:8];

  // result word: busy bit set means complete; low bits carry read data
  always_comb begin
    result = '0;
    result[`JFP_BUSY_BIT] = ~busy;
    result[7:0] = data_word[7:0];
  end

  // (RL13) serial command register, result shifts out
  always_ff @(posedge mclk) begin
    if (reset) begin
      cmd_reg <= '0;
    end else if (on_capture && cmd_sel) begin
      // (RL22) capture loads previous result
      cmd_reg <= result;
    end else if (on_capture && read_sel) begin
      // (RL5) capture current byte, low or high
      cmd_reg[7:0] <= eff_high ? mem_rdata[15:8] : mem_rdata[7:0];
    end else if (on_shift && cmd_sel) begin
      cmd_reg <= {tdi_sync[1], cmd_reg[`JFP_CMD_W-1:1]};
    end else if (on_shift && (load_sel || read_sel)) begin
      // (RL7) page byte register shift
      // (RL4) (RL21) low 8 bits of the command register
      cmd_reg[7:0] <= {tdi_sync[1], cmd_reg[7:1]};
    end
  end

  // serial output from the selected register's low end
  always_ff @(posedge mclk) begin
    if (reset) begin
      tdo <= 1'b0;
    end else if (key_sel) begin
      tdo <= key_reg[0];
    end else if (reset_reg_sel) begin
      tdo <= reset_bit;
    end else begin
      tdo <= cmd_reg[0];
    end
  end

  // (RL22) update applies the command
  always_ff @(posedge mclk) begin
    if (reset) begin
      applied_cmd <= '0;
    end else if (on_update && cmd_sel) begin
      applied_cmd <= cmd_reg;
    end
  end

  // (RL22) one execution step per idle pass
  // (RL14) (RL15) (RL16) (RL17) (RL18) (RL19) (RL20) command decode
  always_ff @(posedge mclk) begin
    if (reset) begin
      mode        <= '0;
      word_addr   <= '0;
      data_word   <= '0;
      ee_byte     <= '0;
      latch_armed <= 1'b0;
      busy_count  <= '0;
    end else begin
      if (busy_count != 16'h0000) begin
        busy_count <= busy_count - 16'h0001;
      end
      if (on_idle && cmd_sel) begin
        latch_armed <= (op == `JFP_CMD_LATCH);
        unique case (op)
          `JFP_CMD_ENTER:     mode <= applied_cmd[7:0];
          `JFP_CMD_ADDR_EXT:  word_addr[16] <= applied_cmd[0];
          `JFP_CMD_ADDR_HI:   word_addr[15:8] <= applied_cmd[7:0];
          `JFP_CMD_ADDR_LO:   word_addr[7:0] <= applied_cmd[7:0];
          `JFP_CMD_DATA_LO:   begin
            data_word[7:0] <= applied_cmd[7:0];
            ee_byte        <= applied_cmd[7:0];
          end
          `JFP_CMD_DATA_HI:   data_word[15:8] <= applied_cmd[7:0];
          `JFP_CMD_WRITE_GO,
          `JFP_CMD_ERASE_GO:  busy_count <= BUSY_CYCLES;
          `JFP_CMD_RD_LO:     data_word[7:0] <= mem_rdata[7:0];
          `JFP_CMD_LATCH_GO:  begin
            if (mode == `JFP_MODE_FLASH_RD) begin
              data_word[7:0] <= mem_rdata[15:8];
            end
          end
          default: ;
        endcase
      end
    end
  end
  assign busy = busy_count != 16'h0000;

  // ****************************************************************
  // page load and page read sequencing
  // ****************************************************************
  // a fresh instruction counts as low byte, first word, even at its own first rise
  assign eff_high  = high_next & ~fresh_instr;
  assign eff_first = first_load | fresh_instr;
  // (RL2) alternation, restarted on entering the instruction
  always_ff @(posedge mclk) begin
    if (reset) begin
      high_next  <= 1'b0;
      first_load <= 1'b1;
    end else if ((on_update && load_sel) || (on_capture && read_sel)) begin
      high_next  <= ~eff_high;
      first_load <= 1'b0;
    end else if (entered_instr) begin
      high_next  <= 1'b0;
      first_load <= 1'b1;
    end
  end

  // (RL1) holding register and write countdown
  always_ff @(posedge mclk) begin
    if (reset) begin
      hold_byte  <= '0;
      load_count <= '0;
    end else if (on_update && load_sel) begin
      hold_byte  <= cmd_reg[7:0];
      load_count <= 4'd1;
    end else if (load_count != 4'd0) begin
      load_count <= 4'd0;
    end
  end

  logic [15:0] page_word;
  // assembled word for the page buffer
  always_ff @(posedge mclk) begin
    if (reset) begin
      page_word <= '0;
    end else if (load_count != 4'd0) begin
      if (high_next) begin
        page_word[7:0] <= hold_byte;
      end else begin
        page_word[15:8] <= hold_byte;
      end
    end
  end

  // (RL3) pre-increment before low byte, not the first
  // (RL6) post-increment after each high byte read
  always_ff @(posedge mclk) begin
    if (reset) begin
      mem_wr <= 1'b0;
    end else begin
      mem_wr <= (load_count != 4'd0) || (on_idle && cmd_sel && latch_armed
                && op == `JFP_CMD_LATCH_GO);
    end
  end

  logic [`JFP_ADDR_W-1:0] load_addr;
  // (RL3) (RL6) first word from the preset address, then stepping
  always_ff @(posedge mclk) begin
    if (reset) begin
      load_addr <= '0;
    end else if ((on_update && load_sel) || (on_capture && read_sel)) begin
      if (eff_first) begin
        load_addr <= word_addr;
      end else if (on_update ? !eff_high : eff_high) begin
        // loads step before a low byte, reads after a high byte
        load_addr <= load_addr + 1'b1;
      end
    end
  end

  // eeprom writes take the single data byte in both halves
  assign mem_wdata = (load_count != 4'd0 || mem_wr && load_sel) ? page_word
                   : (mode == `JFP_MODE_EE_WR) ? {ee_byte, ee_byte} : data_word;

  jfp_mem #(
    .ADDR_W (`JFP_ADDR_W),
    .DEPTH  (MEM_DEPTH)
  ) u_mem (
    .mclk    (mclk),
    .wr_en   (mem_wr),
    .wr_addr (load_sel ? load_addr : word_addr),
    .wr_data (mem_wdata),
    .rd_addr ((read_sel && !eff_first) ? load_addr : word_addr),
    .rd_data (mem_rdata)
  );
endmodule

// ### design/jfp_map.svh
// offsets, field positions, codes and timing counts of the flash programming port
`ifndef JFP_MAP_SVH
`define JFP_MAP_SVH
`define JFP_INSTR_W        4
`define JFP_INSTR_KEY      4'h4
`define JFP_INSTR_CMD      4'h5
`define JFP_INSTR_LOAD     4'h6
`define JFP_INSTR_READ     4'h7
`define JFP_KEY_VALUE      16'hA370
`define JFP_KEY_W          16
`define JFP_CMD_W          15
`define JFP_BYTE_W         8
`define JFP_ADDR_W         17
`define JFP_LOAD_LIMIT     11
`define JFP_CMD_ENTER      7'h23
`define JFP_CMD_ADDR_EXT   7'h0B
`define JFP_CMD_ADDR_HI    7'h07
`define JFP_CMD_ADDR_LO    7'h03
`define JFP_CMD_DATA_LO    7'h13
`define JFP_CMD_DATA_HI    7'h17
`define JFP_CMD_LATCH      7'h77
`define JFP_CMD_LATCH_GO   7'h37
`define JFP_CMD_WRITE_GO   7'h35
`define JFP_CMD_ERASE_GO   7'h31
`define JFP_CMD_RD_LO_SET  7'h32
`define JFP_CMD_RD_LO      7'h36
`define JFP_CMD_IDLE_LO    7'h33
`define JFP_MODE_ERASE     8'h80
`define JFP_MODE_FLASH_WR  8'h10
`define JFP_MODE_FLASH_RD  8'h02
`define JFP_MODE_EE_WR     8'h11
`define JFP_BUSY_BIT       9
`define JFP_BUSY_CYCLES    16'h0040
`define JFP_TIMEOUT_CYCLES 16'h0100
`endif

// ### design/jfp_pkg.sv
// types of the flash programming port
package jfp_pkg;
  typedef enum logic [5:0] {
    JFP_ST_RESET   = 6'b00_0001,
    JFP_ST_IDLE    = 6'b00_0010,
    JFP_ST_CAPTURE = 6'b00_0100,
    JFP_ST_SHIFT   = 6'b00_1000,
    JFP_ST_UPDATE  = 6'b01_0000,
    JFP_ST_OTHER   = 6'b10_0000
  } jfp_tap_type;
endpackage

// ### design/jfp_mem.sv
// word memory standing in for flash page buffer and array, registered read
module jfp_mem #(
  parameter int ADDR_W = 17,
  parameter int DEPTH  = 1024
) (
  input  wire logic              mclk,
  input  wire logic              wr_en,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic [15:0]       wr_data,
  input  wire logic [ADDR_W-1:0] rd_addr,
  output logic      [15:0]       rd_data
);
  logic [15:0] words [DEPTH];
  initial begin
    if (DEPTH < 2 || DEPTH > (1 << ADDR_W)) $error("jfp_mem: bad depth");
  end
  // write port, address folded into the memory depth
  always_ff @(posedge mclk) begin
    if (wr_en) begin
      words[wr_addr % DEPTH] <= wr_data;
    end
  end
  // read data leave through a register
  always_ff @(posedge mclk) begin
    rd_data <= words[rd_addr % DEPTH];
  end
endmodule

// ### test/jfp_port_monitor.sv
// port assertions of the flash programming port
`include "jfp_map.svh"
module jfp_port_monitor #(
  parameter logic [15:0] TIMEOUT_CYCLES = `JFP_TIMEOUT_CYCLES
) (
  input wire logic                    mclk,
  input wire logic                    reset,
  input wire logic                    tck,
  input wire logic                    tdi,
  input wire jfp_pkg::jfp_tap_type    tap_state,
  input wire logic [`JFP_INSTR_W-1:0] instr,
  input wire logic                    reset_reg_sel,
  input wire logic                    tdo,
  input wire logic                    part_reset,
  input wire logic                    prog_enabled
);
  import jfp_pkg::*;
  // ****
  // checks
  // ****
  logic [15:0] hi_run;
  default clocking dc @(posedge mclk); endclocking
  default disable iff (reset);
  // length of the current part reset, measures the time-out
  always_ff @(posedge mclk) begin
    if (reset || !part_reset) hi_run <= 16'h0000;
    else hi_run <= hi_run + 16'h0001;
  end
  sequence rel_seq; (part_reset && !prog_enabled && !tdo)[*4]; endsequence
  sequence sel_shift; reset_reg_sel && tap_state == JFP_ST_SHIFT && $rose(tck); endsequence
  sequence key_upd;
    tap_state == JFP_ST_UPDATE && instr == `JFP_INSTR_KEY && !reset_reg_sel;
  endsequence
  rel_hold_a: assert property ($fell(reset) |-> rel_seq)
    else $error("outputs not at reset values after release");
  tmo_end_a: assert property ($fell(reset) |-> ##[1:40] !part_reset)
    else $error("part reset never released");
  tmo_len_a: assert property ($fell(part_reset) |-> $past(hi_run) >= TIMEOUT_CYCLES - 16'h0002)
    else $error("part reset too short");
  reg_set_a: assert property (sel_shift ##0 tdi |-> ##[1:8] part_reset)
    else $error("part reset did not follow reset bit");
  reg_clr_a: assert property (sel_shift ##0 !tdi |-> ##[1:40] !part_reset)
    else $error("part reset stuck after clear");
  reg_hold_a: assert property (reset_reg_sel && $past(reset_reg_sel, 2) && tdo |-> part_reset)
    else $error("part reset low while reset bit set");
  key_rise_a: assert property ($rose(prog_enabled) |-> key_upd)
    else $error("programming enabled outside key update");
  key_fall_a: assert property ($fell(prog_enabled) |-> key_upd)
    else $error("programming disabled outside key update");
endmodule
bind jfp_port jfp_port_monitor #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_mon (
  .mclk(mclk), .reset(reset), .tck(tck), .tdi(tdi), .tap_state(tap_state),
  .instr(instr), .reset_reg_sel(reset_reg_sel), .tdo(tdo),
  .part_reset(part_reset), .prog_enabled(prog_enabled));

// ### test/jfp_prog.sv
// behavioural test-port programmer facing the flash programming port
`include "jfp_map.svh"
module jfp_prog (
  output logic                  tck,
  output logic                  tdi,
  output jfp_pkg::jfp_tap_type  tap_state,
  output logic [3:0]            instr,
  output logic                  reset_reg_sel,
  input  wire logic             tdo
);
  timeunit 1ns;
  timeprecision 10ps;
  import jfp_pkg::*;
  // ****
  // test clock frames
  // ****
  // tck stands still low between frames
  initial begin
    tck = 1'b0;
    tdi = 1'b0;
    tap_state = JFP_ST_IDLE;
    instr = `JFP_INSTR_CMD;
    reset_reg_sel = 1'b0;
  end
  // one 125 ns test clock; tdo is taken just before the rise it belongs to
  task automatic step(input jfp_tap_type st, input logic b, output logic o);
    #31.25;
    tap_state = st;
    tdi = b;
    #31.25;
    o = tdo;
    tck = 1'b1;
    #62.5;
    tck = 1'b0;
  endtask
  // capture, shift lsb first, update, idle step for commands
  task automatic scan(input logic [3:0] ins, input logic sel, input int n,
                      input logic [15:0] d, output logic [15:0] r);
    logic o;
    int   i;
    #31.25;
    instr = ins;
    reset_reg_sel = sel;
    r = 16'h0000;
    step(JFP_ST_CAPTURE, tdi, o);
    for (i = 0; i < n; i++) begin
      step(JFP_ST_SHIFT, d[i], o);
      r[i] = o;
    end
    step(JFP_ST_UPDATE, ~tdi, o);
    if (ins == `JFP_INSTR_CMD && !sel) step(JFP_ST_IDLE, ~tdi, o);
    // released data line shows the inverse after command scans, but the last shifted bit again after scans without an idle step
    tdi = ~tdi;
  endtask
endmodule

// ### test/jfp_port_tb.sv
// self-checking bench of the flash programming port
`include "jfp_map.svh"
module jfp_port_tb;
  timeunit 1ns;
  timeprecision 10ps;
  import jfp_pkg::*;
  // ****
  // bench set-up
  // ****
  localparam logic [15:0] TO = 16'h0008;
  logic        mclk = 1'b0;
  logic        reset = 1'b1;
  logic        tck, tdi, reset_reg_sel, tdo, part_reset, prog_enabled;
  logic [3:0]  instr;
  jfp_tap_type tap_state;
  logic [15:0] res;
  logic [15:0] mem [int];
  bit          en;
  int          err_count, checks_done;
  integer      seed = 32'h78ca_fe6c;
  // erase with poll, then eeprom write and page write
  logic [14:0] tail [16] = '{15'h2380, 15'h3180, 15'h3380, 15'h3380, 15'h3380, 15'h2311,
    15'h0700, 15'h0305, 15'h135a, 15'h3700, 15'h7700, 15'h3700, 15'h3300, 15'h3100,
    15'h3300, 15'h3300};
  // 100 MHz system clock
  always #5 mclk = ~mclk;
  jfp_port #(.BUSY_CYCLES(16'h0004), .TIMEOUT_CYCLES(TO)) u_jfp_port (
    .mclk(mclk), .reset(reset), .tck(tck), .tdi(tdi), .tap_state(tap_state),
    .instr(instr), .reset_reg_sel(reset_reg_sel), .tdo(tdo),
    .part_reset(part_reset), .prog_enabled(prog_enabled));
  jfp_prog u_jfp_prog (.tck(tck), .tdi(tdi), .tap_state(tap_state), .instr(instr),
    .reset_reg_sel(reset_reg_sel), .tdo(tdo));
  // ****
  // tasks
  // ****
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    if (err_count == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic cmd(input logic [14:0] c);
    u_jfp_prog.scan(`JFP_INSTR_CMD, 1'b0, 15, {1'b0, c}, res);
  endtask
  task automatic rr(input logic b);
    u_jfp_prog.scan(`JFP_INSTR_KEY, 1'b1, 1, {15'h0000, b}, res);
    cmp(16'(part_reset), 16'(b));
  endtask
  task automatic key(input logic [15:0] k);
    u_jfp_prog.scan(`JFP_INSTR_KEY, 1'b0, 16, k, res);
    en = (k == `JFP_KEY_VALUE);
    cmp(16'(prog_enabled), 16'(en));
  endtask
  // mode entry then extended, high, low address
  task automatic seta(input logic [7:0] mode, input logic [16:0] a);
    cmd({`JFP_CMD_ENTER, mode});
    cmd({`JFP_CMD_ADDR_EXT, 7'h00, a[16]});
    cmd({`JFP_CMD_ADDR_HI, a[15:8]});
    cmd({`JFP_CMD_ADDR_LO, a[7:0]});
  endtask
  // data bytes, latch, page write, poll; a refused write leaves the model alone
  task automatic wr(input logic [16:0] a, input logic [15:0] w);
    seta(`JFP_MODE_FLASH_WR, a);
    cmd({`JFP_CMD_DATA_LO, w[7:0]});
    cmd({`JFP_CMD_DATA_HI, w[15:8]});
    cmd({`JFP_CMD_LATCH_GO, 8'h00});
    cmd({`JFP_CMD_LATCH, 8'h00});
    cmd({`JFP_CMD_LATCH_GO, 8'h00});
    cmd({`JFP_CMD_WRITE_GO, 8'h00});
    cmd({`JFP_CMD_LATCH_GO, 8'h00});
    cmd({`JFP_CMD_LATCH_GO, 8'h00});
    if (en) mem[int'(a)] = w;
    if (en) cmp(16'(res[`JFP_BUSY_BIT]), 16'h0001);
  endtask
  task automatic rd(input logic [16:0] a);
    logic [7:0] lo;
    seta(`JFP_MODE_FLASH_RD, a);
    cmd({`JFP_CMD_RD_LO_SET, 8'h00});
    cmd({`JFP_CMD_RD_LO, 8'h00});
    cmd({`JFP_CMD_LATCH_GO, 8'h00});
    lo = res[7:0];
    cmd({`JFP_CMD_IDLE_LO, 8'h00});
    cmp({res[7:0], lo}, mem[int'(a)]);
  endtask
  task automatic pl(input logic [16:0] a, input int n);
    logic [15:0] w;
    int          i;
    seta(`JFP_MODE_FLASH_WR, a);
    for (i = 0; i < n; i++) begin
      w = 16'($random(seed));
      u_jfp_prog.scan(`JFP_INSTR_LOAD, 1'b0, 8, {8'h00, w[7:0]}, res);
      u_jfp_prog.scan(`JFP_INSTR_LOAD, 1'b0, 8, {8'h00, w[15:8]}, res);
      // one word address step per pair
      if (en) mem[int'(a) + i] = w;
    end
  endtask
  task automatic pr(input logic [16:0] a, input int n);
    logic [7:0] lo;
    int         i;
    seta(`JFP_MODE_FLASH_RD, a);
    for (i = 0; i < n; i++) begin
      u_jfp_prog.scan(`JFP_INSTR_READ, 1'b0, 8, 16'h0000, res);
      lo = res[7:0];
      u_jfp_prog.scan(`JFP_INSTR_READ, 1'b0, 8, 16'h0000, res);
      cmp({res[7:0], lo}, mem[int'(a) + i]);
    end
  endtask
  // ****
  // sequence
  // ****
  initial begin
    repeat (10) @(posedge mclk);
    #1 cmp({13'h0000, tdo, part_reset, prog_enabled}, 16'h0002);
    reset = 1'b0;
    repeat (4) @(posedge mclk);
    #1 cmp(16'(part_reset), 16'h0001);
    repeat (int'(TO) + 4) @(posedge mclk);
    #1 cmp(16'(part_reset), 16'h0000);
    rr(1'b1);
    rr(1'b0);
    key(16'h1234);
    key(`JFP_KEY_VALUE);
    wr(17'h00010, 16'($random(seed)));
    rd(17'h00010);
    pl(17'h00020, 4);
    pr(17'h00020, 4);
    pr(17'h00022, 2);
    rd(17'h00021);
    key(16'h0000);
    wr(17'h00010, 16'h5a5a);
    pl(17'h00020, 2);
    key(`JFP_KEY_VALUE);
    rd(17'h00010);
    pr(17'h00020, 2);
    for (int i = 0; i < 16; i++) begin
      cmd(tail[i]);
      if (i == 5) cmp(16'(res[`JFP_BUSY_BIT]), 16'h0001);
      if (i == 15) cmp(16'(res[`JFP_BUSY_BIT]), 16'h0001);
    end
    test_done;
  end
  // watchdog well beyond the expected run of some 240 us
  initial begin
    #900us;
    err_count++;
    test_done;
  end
endmodule
